// ### sim/iocr_board.sv
// Board side of the two-way pins.
// Assumes the board always drives where the cell does not.
`timescale 1ns/1ps
module iocr_board (
  input  wire [7:0] pad_out,
  input  wire [7:0] pad_oe,
  input  wire [7:0] board_val,
  output wire [7:0] pad_in
);
  // Cell wins where it drives, so its own level is read back
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_val);
endmodule // iocr_board

// ### sim/iocr_io_cell_routing_tb.sv
// Bench for the I/O cell block: pads, control lines, nets, routing.
// Assumes the board model on the pads and the bound checker.
`timescale 1ns/1ps
`include "iocr_defs.vh"
`define CHK(n, e, g) begin n_checks = n_checks + 1; if ((g) !== (e)) \
  begin errors = errors + 1; $display("mismatch %0s %h %h", n, e, g); end end
module iocr_io_cell_routing_tb;
  reg clk, reset, chip_wide_reset, chip_tristate_pin, tristate_feature_en;
  reg ded_clk_invert;
  reg [5:0] ded_in;
  reg [11:0] row_first_lc, col_feed, line_invert;
  reg [35:0] line_src_sel;
  reg [15:0] cell_dir, cell_reg_use, cell_clk_sel, cell_clr_sel;
  reg [23:0] cell_gate_sel;
  reg [31:0] cell_oe_sel, cell_out_ch_sel;
  reg [7:0] cell_delay_en, cell_out_from_col, lc_gate, lc_oe, board_val;
  reg [15:0] row_chan, col_chan;
  wire [7:0] pad_in, pad_out, pad_oe;
  wire [15:0] row_drive, col_drive;
  wire [3:0] fanout_net;
  integer errors, n_checks, i;
  iocr_io_cell_routing i_dut (.*);
  iocr_board i_board (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task step(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Slow pin clock so every pipeline stage sees each level
  task pulse;
    ded_in[0] = 1'b1;
    step(4);
    ded_in[0] = 1'b0;
    step(4);
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    errors = errors + 1;
    results;
  end
  initial begin
    errors = 0;
    n_checks = 0;
    reset = 1'b1;
    {chip_wide_reset, chip_tristate_pin} = 2'h1;
    {tristate_feature_en, ded_clk_invert} = 2'h0;
    {ded_in, row_first_lc, col_feed, line_invert} = 42'h0;
    {line_src_sel, cell_gate_sel, cell_clr_sel} = 76'h0;
    {cell_dir, cell_reg_use, cell_clk_sel} = 48'h001100220022;
    {cell_oe_sel, cell_out_ch_sel} = 64'h0000080900000100;
    {cell_delay_en, cell_out_from_col} = 16'h0804;
    {lc_gate, lc_oe, board_val, row_chan, col_chan} = 56'h00040000000000;
    step(2);
    reset = 1'b0;
    step(2);
    row_chan[0] = 1'b1;
    col_chan[5] = 1'b1;
    pulse;
    `CHK("pad_out", 8'h05, pad_out & 8'h05)
    `CHK("pad_oe", 8'h05, pad_oe)
    cell_gate_sel[2:0] = `IOCR_GT_LC;
    {row_chan[0], col_chan[5]} = 2'h0;
    pulse;
    `CHK("gated", 8'h01, pad_out & 8'h05)
    lc_gate[0] = 1'b1;
    ded_clk_invert = 1'b1;
    step(4);
    {col_chan[5], ded_in[0]} = 2'h3;
    step(4);
    `CHK("inv rise", 1'b0, pad_out[2])
    ded_in[0] = 1'b0;
    step(4);
    `CHK("inv fall", 1'b1, pad_out[2])
    ded_clk_invert = 1'b0;
    line_src_sel[26:24] = 3'h3;
    cell_clr_sel[1:0] = `IOCR_CLR_R0;
    row_chan[0] = 1'b1;
    pulse;
    ded_in[3] = 1'b1;
    step(6);
    `CHK("clear", 8'h04, pad_out & 8'h05)
    ded_in[3] = 1'b0;
    chip_wide_reset = 1'b1;
    pulse;
    `CHK("chip reset", 8'h00, pad_out & 8'h05)
    chip_wide_reset = 1'b0;
    $display("register tests done");
    {line_src_sel[2:0], cell_oe_sel[3:0], ded_in[4]} = 8'h81;
    step(4);
    `CHK("line oe", 8'h05, pad_oe)
    cell_oe_sel[3:0] = `IOCR_OE_ON;
    {tristate_feature_en, chip_tristate_pin} = 2'h2;
    step(4);
    `CHK("float", 8'h00, pad_oe)
    tristate_feature_en = 1'b0;
    line_src_sel[35:18] = {3'h2, 3'h0, 3'h2, 3'h3, 3'h2, 3'h2};
    {line_invert[11], ded_in[2]} = 2'h3;
    step(4);
    `CHK("fanout", 4'h7, fanout_net)
    line_src_sel[29:21] = {`IOCR_SRC_ROW, 3'h3, `IOCR_SRC_COL};
    {row_first_lc[9], ded_in[2]} = 2'h2;
    step(4);
    `CHK("fanout src", 4'hC, fanout_net)
    $display("line tests done");
    board_val = 8'h0A;
    i = 0;
    while (row_drive[2] !== 1'b1 && i < 8) begin
      step(1);
      i = i + 1;
    end
    `CHK("col in", 2'h3, col_drive[3:2])
    `CHK("early", 1'b0, row_drive[6])
    step(1);
    `CHK("delayed", 2'h3, row_drive[7:6])
    $display("input tests done");
    results;
  end
endmodule // iocr_io_cell_routing_tb

// ### sim/iocr_monitor.sv
// Checker for the I/O cell block, bound to its top module.
// Assumes one clock and the reset as disable.
`timescale 1ns/1ps
`include "iocr_defs.vh"
module iocr_monitor (
  input wire        clk,
  input wire        reset,
  input wire        chip_wide_reset,
  input wire        chip_tristate_pin,
  input wire        tristate_feature_en,
  input wire [5:0]  ded_in,
  input wire [35:0] line_src_sel,
  input wire [11:0] line_invert,
  input wire [15:0] cell_dir,
  input wire [15:0] cell_reg_use,
  input wire [15:0] cell_clr_sel,
  input wire [23:0] cell_gate_sel,
  input wire [31:0] cell_oe_sel,
  input wire [7:0]  lc_gate,
  input wire [7:0]  pad_out,
  input wire [7:0]  pad_oe,
  input wire [15:0] row_drive,
  input wire [15:0] col_drive,
  input wire [3:0]  fanout_net
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  wire out0 = cell_dir[1:0] == `IOCR_DIR_OUT
              && cell_reg_use[1:0] == `IOCR_USE_OUT;
  copies_equal_a: assert property (
    (((row_drive ^ (row_drive >> 1)) | (col_drive ^ (col_drive >> 1)))
     & 16'h5555) == 16'h0000) else $error("channel copies differ");
  float_all_a: assert property (
    (tristate_feature_en && !chip_tristate_pin) [*3] |-> pad_oe == 8'h00)
    else $error("pad driven while floated");
  input_quiet_a: assert property (
    (cell_dir[3:2] == `IOCR_DIR_IN) [*3] |-> !pad_oe[1])
    else $error("input cell drives pad");
  drive_on_a: assert property (
    (out0 && cell_oe_sel[3:0] == `IOCR_OE_ON && !tristate_feature_en) [*3]
    |-> pad_oe[0]) else $error("forced enable missing");
  chip_clear_a: assert property (
    (chip_wide_reset && out0 && cell_reg_use[5:4] == `IOCR_USE_OUT) [*3]
    |-> (pad_out & 8'h05) == 8'h00)
    else $error("chip reset ignored");
  fan_follow_a: assert property (
    (line_src_sel[20:18] == 3'h2 && !line_invert[6]) [*3]
    |-> fanout_net[0] == $past(ded_in[2], 2)) else $error("net 0 wrong");
  fan_invert_a: assert property (
    (line_src_sel[35:33] == 3'h2 && line_invert[11]) [*3]
    |-> fanout_net[3] == !$past(ded_in[2], 2)) else $error("net 3 wrong");
  line_clear_a: assert property (
    (cell_clr_sel[1:0] == `IOCR_CLR_R0 && line_src_sel[26:24] == 3'h3
     && !line_invert[8] && ded_in[3] && out0) [*5] |-> !pad_out[0])
    else $error("clear ignored");
  gate_hold_a: assert property (
    (cell_gate_sel[2:0] == `IOCR_GT_LC && !lc_gate[0] && out0
     && cell_clr_sel[1:0] == 2'h0 && !chip_wide_reset) [*4]
    |=> $stable(pad_out[0])) else $error("gated register moved");
endmodule // iocr_monitor
bind iocr_io_cell_routing iocr_monitor i_mon (.*);

// ### src/iocr_defs.vh
// Constants for the I/O cell control and routing block.
// Assumes a single 50 MHz clock; included by bare name.
`ifndef IOCR_DEFS_VH
`define IOCR_DEFS_VH
`define IOCR_NCELL     8
`define IOCR_NLINE     12
`define IOCR_NDED      6
`define IOCR_NROWCH    16
`define IOCR_NCOLCH    16
`define IOCR_COL_STEP  2
`define IOCR_DED_CLK_HI 1
// Line roles on the shared control bus
`define IOCR_LN_OE6    7
`define IOCR_LN_OE7    9
`define IOCR_LN_OE_HI  5
`define IOCR_LN_GATE0  6
`define IOCR_LN_TIME0  6
`define IOCR_LN_TIME1  11
`define IOCR_LN_RST0   8
`define IOCR_LN_RST1   10
`define IOCR_LN_FAN0   6
`define IOCR_LN_FAN1   7
`define IOCR_LN_FAN2   9
`define IOCR_LN_FAN3   11
// Line source codes, 3 bits
`define IOCR_SRC_ROW   3'h6
`define IOCR_SRC_COL   3'h7
// Register clock select, 2 bits
`define IOCR_CK_T0     2'h0
`define IOCR_CK_T1     2'h1
`define IOCR_CK_D0     2'h2
`define IOCR_CK_D1     2'h3
// Register clear select, 2 bits
`define IOCR_CLR_R0    2'h1
`define IOCR_CLR_R1    2'h2
// Clock enable select, 3 bits
`define IOCR_GT_ON     3'h0
`define IOCR_GT_LC     3'h7
`define IOCR_GT_LINE0  3'h1
// Drive enable select, 4 bits
`define IOCR_OE_LC     4'h8
`define IOCR_OE_ON     4'h9
// Register use, 2 bits
`define IOCR_USE_IN    2'h1
`define IOCR_USE_OUT   2'h2
// Cell direction, 2 bits
`define IOCR_DIR_IN    2'h0
`define IOCR_DIR_OUT   2'h1
`define IOCR_DIR_BI    2'h2
`endif

// ### src/iocr_io_cell_routing.v
// I/O cell array with shared peripheral control bus and channel routing.
// Assumes all pin and fabric inputs are synchronous to clk; cell clocks
// are sampled levels turned into one-cycle enables.
// chip_wide_reset acts as a synchronous override above clear and capture.
// Function
// - Each cell has a two-way buffer and one register, input or output.
// - Twelve shared lines: up to 8 enables, 6 gates, 2 clocks, 2 clears.
// - Each cell picks its own clock, clear, gate and drive enable.
// - Gate and drive enable may come straight from a logic cell.
// - Cell register may also clock from either dedicated clock pin.
// - A line is driven by a dedicated input, row logic cell or column.
// - Chip-wide reset clears every cell register, overriding all else.
// - One dedicated clock polarity applies to all cells.
// - Both clock senses need two bus lines, one per sense.
// - True and inverted control signals each occupy their own line.
// - Six lines are drive enables; six are gates with fixed extra roles.
// - Bus lines drive four global low-skew nets.
// - A logic cell reaches a global net via its row line and bus.
// - When enabled, a low chip tristate pin floats every pin.
// - Optional delay on the pad-to-routing path, per cell.
// - An input cell drives two row channels.
// - An output cell takes its data from a row or column channel multiplexer.
// - An input cell drives at most two column channels.
// - Output column multiplexer set differs from cell to cell.
// - Six dedicated low-skew inputs serve controls or data.
`timescale 1ns/1ps
`include "iocr_defs.vh"

module iocr_io_cell_routing (
  input  wire                              clk,
  input  wire                              reset,
  input  wire                              chip_wide_reset,
  input  wire                              chip_tristate_pin,
  input  wire                              tristate_feature_en,
  input  wire [`IOCR_NDED-1:0]             ded_in,
  input  wire                              ded_clk_invert,
  input  wire [`IOCR_NLINE-1:0]            row_first_lc,
  input  wire [`IOCR_NLINE-1:0]            col_feed,
  input  wire [3*`IOCR_NLINE-1:0]          line_src_sel,
  input  wire [`IOCR_NLINE-1:0]            line_invert,
  input  wire [2*`IOCR_NCELL-1:0]          cell_dir,
  input  wire [2*`IOCR_NCELL-1:0]          cell_reg_use,
  input  wire [2*`IOCR_NCELL-1:0]          cell_clk_sel,
  input  wire [2*`IOCR_NCELL-1:0]          cell_clr_sel,
  input  wire [3*`IOCR_NCELL-1:0]          cell_gate_sel,
  input  wire [4*`IOCR_NCELL-1:0]          cell_oe_sel,
  input  wire [`IOCR_NCELL-1:0]            cell_delay_en,
  input  wire [`IOCR_NCELL-1:0]            cell_out_from_col,
  input  wire [4*`IOCR_NCELL-1:0]          cell_out_ch_sel,
  input  wire [`IOCR_NCELL-1:0]            lc_gate,
  input  wire [`IOCR_NCELL-1:0]            lc_oe,
  input  wire [`IOCR_NROWCH-1:0]           row_chan,
  input  wire [`IOCR_NCOLCH-1:0]           col_chan,
  input  wire [`IOCR_NCELL-1:0]            pad_in,
  output wire [`IOCR_NCELL-1:0]            pad_out,
  output wire [`IOCR_NCELL-1:0]            pad_oe,
  output wire [2*`IOCR_NCELL-1:0]          row_drive,
  output wire [2*`IOCR_NCELL-1:0]          col_drive,
  output wire [3:0]                        fanout_net
);

  // Shared control bus, one flop per line
  reg  [`IOCR_NLINE-1:0] periph_line_q;
  wire [`IOCR_NLINE-1:0] periph_line_d;
  reg  [3:0]             fanout_q;
  wire [3:0]             fanout_d;
  wire [5:0]             gate_lines;
  wire [7:0]             oe_lines;
  wire [1:0]             ded_clk;
  wire                   float_all;

  genvar g;
  generate
    for (g = 0; g < `IOCR_NLINE; g = g + 1) begin : g_line
      wire [2:0] src;
      reg        raw;
      assign src = line_src_sel[3*g +: 3];
      // Codes below the row code pick a dedicated input by index
      always @* begin
        if (src == `IOCR_SRC_ROW) begin
          raw = row_first_lc[g];
        end else if (src == `IOCR_SRC_COL) begin
          raw = col_feed[g];
        end else begin
          raw = ded_in[src];
        end
      end
      // Each line carries one sense; a second sense needs a second line
      assign periph_line_d[g] = raw ^ line_invert[g];
    end
  endgenerate

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      periph_line_q <= {`IOCR_NLINE{1'b0}};
      fanout_q      <= 4'h0;
    end else begin
      periph_line_q <= periph_line_d;
      fanout_q      <= fanout_d;
    end
  end

  // Second flop re-drives the nets so all four leave from one stage
  assign fanout_d = {periph_line_q[`IOCR_LN_FAN3],
                     periph_line_q[`IOCR_LN_FAN2],
                     periph_line_q[`IOCR_LN_FAN1],
                     periph_line_q[`IOCR_LN_FAN0]};

  assign fanout_net = fanout_q;

  // Fixed sharing pattern of the twelve lines
  assign gate_lines = periph_line_q[`IOCR_NLINE-1:`IOCR_LN_GATE0];
  assign oe_lines   = {periph_line_q[`IOCR_LN_OE7],
                       periph_line_q[`IOCR_LN_OE6],
                       periph_line_q[`IOCR_LN_OE_HI:0]};

  // A single polarity choice serves every cell
  assign ded_clk = ded_in[`IOCR_DED_CLK_HI:0] ^ {2{ded_clk_invert}};

  // Deasserted tristate pin floats all pads only when the feature is on
  assign float_all = tristate_feature_en & ~chip_tristate_pin;

  generate
    for (g = 0; g < `IOCR_NCELL; g = g + 1) begin : g_cell
      wire [1:0] dir;
      wire [1:0] use_sel;
      wire [1:0] ck_sel;
      wire [1:0] clr_sel;
      wire [2:0] gt_sel;
      wire [3:0] oe_sel;
      wire [3:0] ch_sel;
      wire [3:0] col_idx;
      localparam integer COL_OFF_I = g * `IOCR_COL_STEP;
      localparam [3:0]   COL_OFF   = COL_OFF_I[3:0];
      reg        clk_lvl;
      reg        clr_lvl;
      reg        gate_lvl;
      reg        oe_lvl;
      wire       clk_rise;
      wire       out_src;
      wire       pin_val;
      wire       in_val;
      reg        is_in;
      reg        is_out;
      reg        ck_prev_q;
      reg        dly_q;
      reg        cell_reg_q;
      reg        pad_out_q;
      reg        pad_oe_q;
      reg  [1:0] row_drv_q;
      reg  [1:0] col_drv_q;
      reg        cell_reg_d;
      reg        pad_out_d;
      reg        pad_oe_d;
      reg  [1:0] row_drv_d;
      reg  [1:0] col_drv_d;

      assign dir     = cell_dir[2*g +: 2];
      assign use_sel = cell_reg_use[2*g +: 2];
      assign ck_sel  = cell_clk_sel[2*g +: 2];
      assign clr_sel = cell_clr_sel[2*g +: 2];
      assign gt_sel  = cell_gate_sel[3*g +: 3];
      assign oe_sel  = cell_oe_sel[4*g +: 4];
      assign ch_sel  = cell_out_ch_sel[4*g +: 4];

      always @* begin
        case (ck_sel)
          `IOCR_CK_T0: clk_lvl = periph_line_q[`IOCR_LN_TIME0];
          `IOCR_CK_T1: clk_lvl = periph_line_q[`IOCR_LN_TIME1];
          `IOCR_CK_D0: clk_lvl = ded_clk[0];
          default:     clk_lvl = ded_clk[1];
        endcase
      end

      // Clear is sampled by clk, so it acts at the next edge, not at once
      always @* begin
        case (clr_sel)
          `IOCR_CLR_R0: clr_lvl = periph_line_q[`IOCR_LN_RST0];
          `IOCR_CLR_R1: clr_lvl = periph_line_q[`IOCR_LN_RST1];
          default:      clr_lvl = 1'b0;
        endcase
      end

      always @* begin
        if (gt_sel == `IOCR_GT_ON) begin
          gate_lvl = 1'b1;
        end else if (gt_sel == `IOCR_GT_LC) begin
          gate_lvl = lc_gate[g];
        end else begin
          gate_lvl = gate_lines[gt_sel - `IOCR_GT_LINE0];
        end
      end

      // Codes above the on code leave the pad undriven
      always @* begin
        if (oe_sel < `IOCR_OE_LC) begin
          oe_lvl = oe_lines[oe_sel[2:0]];
        end else if (oe_sel == `IOCR_OE_LC) begin
          oe_lvl = lc_oe[g];
        end else if (oe_sel == `IOCR_OE_ON) begin
          oe_lvl = 1'b1;
        end else begin
          oe_lvl = 1'b0;
        end
      end

      // Column set is shifted per cell so neighbours see different channels
      assign col_idx = ch_sel + COL_OFF;
      assign out_src = cell_out_from_col[g] ? col_chan[col_idx] :
                       row_chan[ch_sel];

      // Delay trades setup time for a guaranteed zero hold time
      assign pin_val  = cell_delay_en[g] ? dly_q : pad_in[g];
      assign clk_rise = clk_lvl & ~ck_prev_q;
      assign in_val   = (use_sel == `IOCR_USE_IN) ? cell_reg_q : pin_val;

      // Code 3 parks the cell: it neither listens nor drives
      always @* begin
        case (dir)
          `IOCR_DIR_IN: begin
            is_in  = 1'b1;
            is_out = 1'b0;
          end
          `IOCR_DIR_OUT: begin
            is_in  = 1'b0;
            is_out = 1'b1;
          end
          `IOCR_DIR_BI: begin
            is_in  = 1'b1;
            is_out = 1'b1;
          end
          default: begin
            is_in  = 1'b0;
            is_out = 1'b0;
          end
        endcase
      end

      always @(posedge clk or posedge reset) begin
        if (reset) begin
          ck_prev_q <= 1'b0;
          dly_q     <= 1'b0;
        end else begin
          ck_prev_q <= clk_lvl;
          dly_q     <= pad_in[g];
        end
      end

      // Chip reset first, then clear, then gated capture
      always @* begin
        cell_reg_d = cell_reg_q;
        if (chip_wide_reset) begin
          cell_reg_d = 1'b0;
        end else if (clr_lvl) begin
          cell_reg_d = 1'b0;
        end else if (clk_rise && gate_lvl) begin
          if (use_sel == `IOCR_USE_IN) begin
            cell_reg_d = pin_val;
          end else begin
            cell_reg_d = out_src;
          end
        end
      end

      always @(posedge clk or posedge reset) begin
        if (reset) begin
          cell_reg_q <= 1'b0;
        end else begin
          cell_reg_q <= cell_reg_d;
        end
      end

      // Pad and channel copies are registered so every output is a flop
      always @* begin
        pad_out_d = (use_sel == `IOCR_USE_OUT) ? cell_reg_q : out_src;
        pad_oe_d  = is_out & oe_lvl & ~float_all;
        row_drv_d = is_in ? {2{in_val}} : 2'h0;
        col_drv_d = is_in ? {2{in_val}} : 2'h0;
      end

      always @(posedge clk or posedge reset) begin
        if (reset) begin
          pad_out_q <= 1'b0;
          pad_oe_q  <= 1'b0;
          row_drv_q <= 2'h0;
          col_drv_q <= 2'h0;
        end else begin
          pad_out_q <= pad_out_d;
          pad_oe_q  <= pad_oe_d;
          row_drv_q <= row_drv_d;
          col_drv_q <= col_drv_d;
        end
      end

      assign pad_out[g]         = pad_out_q;
      assign pad_oe[g]          = pad_oe_q;
      assign row_drive[2*g +: 2] = row_drv_q;
      assign col_drive[2*g +: 2] = col_drv_q;
    end
  endgenerate

endmodule // iocr_io_cell_routing
